// [pkg/tos_pkg.sv]
// package of constants and types for the one-shot / monostable timer
package tos_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned TOS_ADDR_W      = 5;
  localparam logic [4:0]  TOS_OFS_CTRL    = 5'h00;
  localparam logic [4:0]  TOS_OFS_PERIOD  = 5'h04;
  localparam logic [4:0]  TOS_OFS_COMPARE = 5'h08;
  localparam logic [4:0]  TOS_OFS_COUNT   = 5'h0C;
  localparam logic [4:0]  TOS_OFS_STATUS  = 5'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned TOS_CTRL_RUN_BIT  = 0;
  localparam int unsigned TOS_CTRL_MODE_LSB = 8;
  localparam int unsigned TOS_CTRL_PSC_LSB  = 16;
  localparam int unsigned TOS_MODE_W        = 5;
  localparam int unsigned TOS_PSC_W         = 4;
  localparam int unsigned TOS_STAT_DRIVE    = 0;
  localparam int unsigned TOS_STAT_ACTIVE   = 1;
  localparam int unsigned TOS_STAT_PAUSED   = 2;

  // ----------------------------------------------------------------
  // mode codes and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] TOS_MODE_ONE_SHOT  = 5'h08;
  localparam logic [4:0] TOS_MODE_MONO_RISE = 5'h11;
  localparam logic [4:0] TOS_MODE_MONO_FALL = 5'h12;
  localparam logic [4:0] TOS_MODE_MONO_BOTH = 5'h13;
  localparam logic [4:0] TOS_MODE_RST       = 5'h00;
  localparam logic [3:0] TOS_PSC_RST        = 4'h0;
  localparam int unsigned TOS_CNT_W_DEF     = 8;

  typedef enum logic [2:0] {
    TOS_ST_IDLE  = 3'b001,
    TOS_ST_RUN   = 3'b010,
    TOS_ST_PAUSE = 3'b100
  } tos_state_t;

endpackage

// [verilog/tos_prescaler.sv]
// timer clock enable divider: one pulse every 2**select cycles
`timescale 1ns/1ns
module tos_prescaler #(
  parameter int unsigned SEL_W = 4
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             nrst_in,
  // divider select and tick
  input  wire logic [SEL_W-1:0] psc_sel_in,
  output logic                  tick_out
);
  import tos_pkg::*;

  localparam int unsigned DIV_W = 1 << SEL_W;

  if (SEL_W < 1 || SEL_W > 5) begin : g_chk
    $error("tos_prescaler: SEL_W out of range");
  end

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic             tick_reg;
  logic             tick_next;
  logic [DIV_W-1:0] mask;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // free running, so a select change takes effect within one period
  always_comb begin
    mask      = DIV_W'((DIV_W'(1) << psc_sel_in) - DIV_W'(1));
    div_next  = DIV_W'(div_reg + DIV_W'(1));
    tick_next = ((div_reg & mask) == mask);
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_out = tick_reg;

endmodule // tos_prescaler

// [verilog/tos_edge_detect.sv]
// edge detector for the external trigger input
`timescale 1ns/1ns
module tos_edge_detect (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic nrst_in,
  // trigger level and edges
  input  wire logic sig_in,
  output logic      rise_out,
  output logic      fall_out
);
  import tos_pkg::*;

  logic cur_reg;
  logic cur_next;
  logic prev_reg;
  logic prev_next;

  // ----------------------------------------------------------------
  // edge pipeline
  // ----------------------------------------------------------------
  // both taps are registered, so edges show one cycle after the pin
  always_comb begin
    cur_next  = sig_in;
    prev_next = cur_reg;
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cur_reg  <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      cur_reg  <= cur_next;
      prev_reg <= prev_next;
    end
  end

  assign rise_out = cur_reg & ~prev_reg;
  assign fall_out = ~cur_reg & prev_reg;

endmodule // tos_edge_detect

// [verilog/tos_timer_top.sv]
// one-shot and edge-triggered monostable timer with pulse drive output
//
// Contract
// - mode value 01000 selects software-start one-shot operation.
// - in one-shot, a period match resets the counter and clears the run bit.
// - clearing run mid-cycle pauses the counter, setting it again resumes.
// - in one-shot, the pulse drive goes active at the edge where run is set.
// - in one-shot, the pulse drive ends when the count equals the compare value.
// - clearing run while the drive is active lengthens the drive.
// - run cleared between compare and period match keeps the drive off and only delays the match.
// - after a completed one-shot cycle the drive stays off until run is set.
// - a new one-shot cycle begins only from run set after a period match.
// - in monostable, with run set, a qualifying trigger edge starts counting.
// - in monostable, the counter stops incrementing at the period match.
// - mode 10001 starts on rising, 10010 on falling, 10011 on either edge.
// - in monostable the drive goes active on the starting edge, never at match.
// - trigger edges during a monostable count do not affect the drive.
`timescale 1ns/1ns
module tos_timer_top #(
  parameter int unsigned CNT_W = tos_pkg::TOS_CNT_W_DEF
) (
  // clock and reset
  input  wire logic                           mclk_in,
  input  wire logic                           nrst_in,
  // avalon-mm slave
  input  wire logic [tos_pkg::TOS_ADDR_W-1:0] avs_address_in,
  input  wire logic                           avs_read_in,
  input  wire logic                           avs_write_in,
  input  wire logic [31:0]                    avs_writedata_in,
  input  wire logic [3:0]                     avs_byteenable_in,
  output logic [31:0]                         avs_readdata_out,
  output logic                                avs_waitrequest_out,
  // trigger and drive
  input  wire logic                           trig_in,
  output logic                                pwm_drive_out,
  output logic                                period_match_out
);
  import tos_pkg::*;

  if (CNT_W < 2 || CNT_W > 16) begin : g_chk
    $error("tos_timer_top: CNT_W out of range");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                  ack_reg;
  logic                  ack_next;
  logic [31:0]           rdata_reg;
  logic [31:0]           rdata_next;
  logic                  run_reg;
  logic                  run_next;
  logic [4:0]            mode_reg;
  logic [4:0]            mode_next;
  logic [3:0]            psc_reg;
  logic [3:0]            psc_next;
  logic [CNT_W-1:0]      period_reg;
  logic [CNT_W-1:0]      period_next;
  logic [CNT_W-1:0]      compare_reg;
  logic [CNT_W-1:0]      compare_next;
  logic [CNT_W-1:0]      count_reg;
  logic [CNT_W-1:0]      count_next;
  logic                  pwm_end_reg;
  logic                  pwm_end_next;
  logic                  drive_reg;
  logic                  drive_next;
  logic                  match_reg;
  logic                  match_next;
  tos_state_t            state_reg;
  tos_state_t            state_next;
  logic                  req;
  logic                  wr_go;
  logic                  ctrl_wr;
  logic                  run_wr;
  logic                  mode_wr;
  logic [31:0]           wmerged;
  logic [31:0]           rd_word;
  logic                  tick;
  logic                  trig_rise;
  logic                  trig_fall;
  logic                  trig_go;
  logic                  is_os;
  logic                  is_mono;
  logic                  counting;
  logic                  hit_period;
  logic                  hit_compare;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  tos_prescaler #(
    .SEL_W      (TOS_PSC_W)
  ) u_psc (
    .mclk_in    (mclk_in),
    .nrst_in    (nrst_in),
    .psc_sel_in (psc_reg),
    .tick_out   (tick)
  );

  tos_edge_detect u_edge (
    .mclk_in  (mclk_in),
    .nrst_in  (nrst_in),
    .sig_in   (trig_in),
    .rise_out (trig_rise),
    .fall_out (trig_fall)
  );

  // ----------------------------------------------------------------
  // avalon slave: one wait state on every access
  // ----------------------------------------------------------------
  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_reg;
  assign wr_go               = avs_write_in & ack_reg;
  assign ctrl_wr             = wr_go & (avs_address_in == TOS_OFS_CTRL);
  assign run_wr              = ctrl_wr & avs_byteenable_in[0];
  assign mode_wr             = ctrl_wr & avs_byteenable_in[1];

  always_comb begin
    rd_word = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      wmerged[i*8 +: 8] = avs_byteenable_in[i] ? avs_writedata_in[i*8 +: 8]
                                               : 8'h00;
    end
    case (avs_address_in)
      TOS_OFS_CTRL: begin
        rd_word[TOS_CTRL_RUN_BIT]               = run_reg;
        rd_word[TOS_CTRL_MODE_LSB +: TOS_MODE_W] = mode_reg;
        rd_word[TOS_CTRL_PSC_LSB +: TOS_PSC_W]   = psc_reg;
      end
      TOS_OFS_PERIOD:  rd_word[CNT_W-1:0] = period_reg;
      TOS_OFS_COMPARE: rd_word[CNT_W-1:0] = compare_reg;
      TOS_OFS_COUNT:   rd_word[CNT_W-1:0] = count_reg;
      TOS_OFS_STATUS: begin
        rd_word[TOS_STAT_DRIVE]  = drive_reg;
        rd_word[TOS_STAT_ACTIVE] = (state_reg != TOS_ST_IDLE);
        rd_word[TOS_STAT_PAUSED] = (state_reg == TOS_ST_PAUSE);
      end
      default: rd_word = 32'h0000_0000;
    endcase
    ack_next   = req & ~ack_reg;
    rdata_next = (avs_read_in & ~ack_reg) ? rd_word : rdata_reg;
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata_out = rdata_reg;

  // ----------------------------------------------------------------
  // mode decode and trigger qualification
  // ----------------------------------------------------------------
  assign is_os   = (mode_reg == TOS_MODE_ONE_SHOT);
  assign is_mono = (mode_reg == TOS_MODE_MONO_RISE) |
                   (mode_reg == TOS_MODE_MONO_FALL) |
                   (mode_reg == TOS_MODE_MONO_BOTH);
  assign trig_go = ((mode_reg == TOS_MODE_MONO_RISE) & trig_rise) |
                   ((mode_reg == TOS_MODE_MONO_FALL) & trig_fall) |
                   ((mode_reg == TOS_MODE_MONO_BOTH) & (trig_rise | trig_fall));
  assign counting    = (state_reg == TOS_ST_RUN) & run_reg & tick;
  assign hit_period  = counting & (count_reg == period_reg);
  assign hit_compare = counting & (count_reg == compare_reg);

  // ----------------------------------------------------------------
  // timer state
  // ----------------------------------------------------------------
  always_comb begin
    mode_next    = mode_wr ? wmerged[TOS_CTRL_MODE_LSB +: TOS_MODE_W] : mode_reg;
    psc_next     = psc_reg;
    period_next  = period_reg;
    compare_next = compare_reg;
    if (ctrl_wr && avs_byteenable_in[2]) begin
      psc_next = wmerged[TOS_CTRL_PSC_LSB +: TOS_PSC_W];
    end
    if (wr_go && avs_address_in == TOS_OFS_PERIOD) begin
      period_next = wmerged[CNT_W-1:0];
    end
    if (wr_go && avs_address_in == TOS_OFS_COMPARE) begin
      compare_next = wmerged[CNT_W-1:0];
    end
    run_next     = run_wr ? wmerged[TOS_CTRL_RUN_BIT] : run_reg;
    state_next   = state_reg;
    count_next   = count_reg;
    pwm_end_next = pwm_end_reg;
    match_next   = 1'b0;
    case (state_reg)
      TOS_ST_IDLE: begin
        // a cycle can only open here; the written mode counts, so mode and run
        // set by one write start the drive at that same edge
        if ((mode_next == TOS_MODE_ONE_SHOT) && run_next) begin
          state_next   = TOS_ST_RUN;
          count_next   = '0;
          pwm_end_next = 1'b0;
        end else if (is_mono && run_reg && trig_go) begin
          state_next   = TOS_ST_RUN;
          count_next   = '0;
          pwm_end_next = 1'b0;
        end
      end
      TOS_ST_RUN: begin
        if (hit_compare) begin
          pwm_end_next = 1'b1;
        end
        if (hit_period) begin
          match_next = 1'b1;
          state_next = TOS_ST_IDLE;
          if (is_os) begin
            count_next = '0;
            // a software write in the same cycle wins over the hardware clear
            if (!run_wr) begin
              run_next = 1'b0;
            end
          end
        end else if (counting) begin
          count_next = CNT_W'(count_reg + CNT_W'(1));
        end
        // edges are ignored here, so a running count is never restarted
        if (!hit_period && !run_next) begin
          state_next = TOS_ST_PAUSE;
        end
      end
      TOS_ST_PAUSE: begin
        if (run_next) begin
          state_next = TOS_ST_RUN;
        end
      end
      default: state_next = TOS_ST_IDLE;
    endcase
    // judged on the written mode, so leaving the timer modes stops at once
    if (!(mode_next inside {TOS_MODE_ONE_SHOT, TOS_MODE_MONO_RISE, TOS_MODE_MONO_FALL,
                            TOS_MODE_MONO_BOTH})) begin
      state_next = TOS_ST_IDLE;
    end
    // drive follows the cycle, so a pause stretches it by the pause time
    drive_next = (state_next != TOS_ST_IDLE) & ~pwm_end_next;
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_reg     <= 1'b0;
      mode_reg    <= TOS_MODE_RST;
      psc_reg     <= TOS_PSC_RST;
      period_reg  <= '1;
      compare_reg <= '0;
      count_reg   <= '0;
      pwm_end_reg <= 1'b0;
      drive_reg   <= 1'b0;
      match_reg   <= 1'b0;
      state_reg   <= TOS_ST_IDLE;
    end else begin
      run_reg     <= run_next;
      mode_reg    <= mode_next;
      psc_reg     <= psc_next;
      period_reg  <= period_next;
      compare_reg <= compare_next;
      count_reg   <= count_next;
      pwm_end_reg <= pwm_end_next;
      drive_reg   <= drive_next;
      match_reg   <= match_next;
      state_reg   <= state_next;
    end
  end

  assign pwm_drive_out    = drive_reg;
  assign period_match_out = match_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  a_os_match_clear: assert property ((hit_period && is_os && !wr_go)
    |=> (!run_reg && count_reg == '0 && state_reg == TOS_ST_IDLE))
    else $error("one-shot period match did not clear run and count");
  a_pause_hold: assert property ((state_reg == TOS_ST_PAUSE && !run_next)
    |=> (count_reg == $past(count_reg) && state_reg == TOS_ST_PAUSE))
    else $error("counter moved while paused");
  a_os_drive_start: assert property ((state_reg == TOS_ST_IDLE &&
    mode_next == TOS_MODE_ONE_SHOT && run_wr && wmerged[TOS_CTRL_RUN_BIT])
    |=> (pwm_drive_out && run_reg))
    else $error("drive not active with run set");
  a_drive_end: assert property ((hit_compare && !wr_go) |=> !pwm_drive_out)
    else $error("drive did not end at compare match");
  a_pause_stretch: assert property ((pwm_drive_out && state_reg == TOS_ST_PAUSE
    && !wr_go) |=> pwm_drive_out)
    else $error("drive dropped during pause");
  a_stretch_exact: assert property ((state_reg == TOS_ST_PAUSE && !pwm_end_reg
    && !wr_go)[*3] |-> pwm_drive_out)
    else $error("drive not held for the whole pause");
  a_idle_no_drive: assert property ((state_reg == TOS_ST_IDLE) |-> !pwm_drive_out)
    else $error("drive active outside a cycle");
  a_os_restart: assert property ((state_reg == TOS_ST_IDLE && is_os && !run_next)
    |=> (state_reg == TOS_ST_IDLE))
    else $error("one-shot cycle opened without run set");
  a_mono_start: assert property ((state_reg == TOS_ST_IDLE && is_mono && run_reg
    && trig_go && !wr_go)
    |=> (state_reg == TOS_ST_RUN && count_reg == '0 && pwm_drive_out))
    else $error("monostable did not start on qualifying edge");
  a_mono_stop: assert property ((hit_period && is_mono && !wr_go)
    |=> (state_reg == TOS_ST_IDLE && count_reg == $past(count_reg)
         && !pwm_drive_out))
    else $error("monostable kept counting past period match");
  a_edge_select: assert property ((state_reg == TOS_ST_IDLE && run_reg && !wr_go &&
    ((mode_reg == TOS_MODE_MONO_FALL && trig_rise) ||
     (mode_reg == TOS_MODE_MONO_RISE && trig_fall))) |=> (state_reg == TOS_ST_IDLE))
    else $error("monostable started on an edge of the wrong kind");
  a_mono_ignore: assert property ((state_reg == TOS_ST_RUN && is_mono &&
    (trig_rise || trig_fall) && !hit_compare && !hit_period && !wr_go)
    |=> (state_reg == TOS_ST_RUN && pwm_drive_out == $past(pwm_drive_out)
         && count_reg == CNT_W'($past(count_reg) + CNT_W'($past(counting)))))
    else $error("trigger edge disturbed a running count");
  a_count_step: assert property ((counting && !hit_period && run_next)
    |=> (count_reg == CNT_W'($past(count_reg) + CNT_W'(1))))
    else $error("counter did not advance by one");

  c_os_cycle: cover property (is_os && hit_period ##1 !run_reg);
  c_os_pause: cover property (pwm_drive_out && state_reg == TOS_ST_PAUSE);
  c_mono_start: cover property (is_mono && state_reg == TOS_ST_IDLE && trig_go
    && run_reg);
  c_mono_edge_run: cover property (is_mono && state_reg == TOS_ST_RUN && trig_go);

endmodule // tos_timer_top

// [test/tos_far_model.sv]
// far-side model: external trigger source and observer of the pulse drive
`timescale 1ns/1ns
module tos_far_model (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  // trigger request and drive sense
  input  wire logic        toggle_in,
  input  wire logic        drive_in,
  // trigger line and drive statistics
  output logic             trig_out,
  output logic [15:0]      width_out,
  output logic [7:0]       pulses_out
);
  logic [15:0] run_reg;
  logic        drv_reg;

  // ----------------------------------------------------------------
  // trigger source
  // ----------------------------------------------------------------
  // the line only moves after a clock edge, so the design sees clean edges
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trig_out <= 1'b0;
    end else if (toggle_in) begin
      trig_out <= ~trig_out;
    end
  end

  // ----------------------------------------------------------------
  // drive observer: width in sampled cycles, count of pulse starts
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_reg    <= 16'h0000;
      drv_reg    <= 1'b0;
      width_out  <= 16'h0000;
      pulses_out <= 8'h00;
    end else begin
      drv_reg <= drive_in;
      run_reg <= drive_in ? run_reg + 16'h0001 : 16'h0000;
      if (drive_in && !drv_reg) begin
        pulses_out <= pulses_out + 8'h01;
      end
      if (!drive_in && drv_reg) begin
        width_out <= run_reg;
      end
    end
  end
endmodule // tos_far_model

// [test/tos_timer_top_tb.sv]
// self-checking bench for the one-shot and monostable timer
`timescale 1ns/1ns
module tos_timer_top_tb;
  import tos_pkg::*;
  localparam int CW = 8;
  logic        mclk_in, nrst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [4:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  logic [3:0]  avs_byteenable_in, be_sel;
  logic        trig_in, pwm_drive_out, period_match_out, toggle;
  logic [15:0] width;
  logic [7:0]  pulses, n0;
  logic [4:0]  m;
  integer      seed;
  int          n_fail, tests_run, cyc, t_match, t_wr, ts, t1, t2, t3, t4, p, c;

  tos_timer_top #(.CNT_W(CW)) i_dut (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .trig_in(trig_in), .pwm_drive_out(pwm_drive_out), .period_match_out(period_match_out));

  tos_far_model i_far (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .toggle_in(toggle), .drive_in(pwm_drive_out),
    .trig_out(trig_in), .width_out(width), .pulses_out(pulses));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] ctrl_word(input logic [4:0] md, input logic run);
    return (32'(md) << TOS_CTRL_MODE_LSB) | 32'(run);
  endfunction

  function automatic logic exp_start(input logic [4:0] md, input logic rise);
    return (md == TOS_MODE_MONO_BOTH) || (rise ? md == TOS_MODE_MONO_RISE
                                               : md == TOS_MODE_MONO_FALL);
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until waitrequest is sampled low; write lands and data is taken there
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    avs_address_in    <= a;
    avs_writedata_in  <= d;
    avs_byteenable_in <= be_sel;
    avs_read_in       <= !wr;
    avs_write_in      <= wr;
    do begin
      @(posedge mclk_in);
    end while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    t_wr = cyc;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      bus(1'b0, TOS_OFS_STATUS, 32'h0);
      k++;
    end while (rd[TOS_STAT_ACTIVE] !== 1'b0 && k < 300);
  endtask

  task automatic tog;
    @(posedge mclk_in);
    toggle <= 1'b1;
    @(posedge mclk_in);
    toggle <= 1'b0;
  endtask

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // cycle count, period match stamp and hang guard
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (period_match_out === 1'b1) begin
      t_match <= cyc;
    end
    if (cyc == 40000) begin
      n_fail++;
      test_done;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst_in = 1'b0; avs_read_in = 1'b0; avs_write_in = 1'b0; avs_address_in = 5'h00;
    avs_writedata_in = 32'h0; avs_byteenable_in = 4'hF; be_sel = 4'hF; toggle = 1'b0;
    seed = 65; n_fail = 0; tests_run = 0; cyc = 0; t_match = 0;
    repeat (10) @(posedge mclk_in);
    nrst_in <= 1'b1;
    // reset values, unmapped place, byte lanes
    rd_chk(TOS_OFS_CTRL, 32'h0, "ctrl reset");
    rd_chk(TOS_OFS_PERIOD, (32'h1 << CW) - 32'h1, "period reset");
    rd_chk(TOS_OFS_COMPARE, 32'h0, "compare reset");
    rd_chk(TOS_OFS_COUNT, 32'h0, "count reset");
    rd_chk(TOS_OFS_STATUS, 32'h0, "status reset");
    bus(1'b1, 5'h14, 32'hFFFFFFFF);
    rd_chk(5'h14, 32'h0, "unmapped");
    be_sel = 4'h2;
    bus(1'b1, TOS_OFS_CTRL, ctrl_word(TOS_MODE_ONE_SHOT, 1'b1));
    be_sel = 4'hF;
    rd_chk(TOS_OFS_CTRL, ctrl_word(TOS_MODE_ONE_SHOT, 1'b0), "ctrl byte lane");
    // no mode selected: run alone makes no pulse
    n0 = pulses;
    bus(1'b1, TOS_OFS_CTRL, ctrl_word(TOS_MODE_RST, 1'b1));
    repeat (12) @(posedge mclk_in);
    chk("no mode pulses", 32'(n0), 32'(pulses));
    // one-shot cycles, boundary compares first
    for (int i = 0; i < 5; i++) begin
      p = 3 + ($unsigned($random(seed)) % 30);
      c = (i == 0) ? 0 : (i == 1) ? p - 1 : $unsigned($random(seed)) % p;
      bus(1'b1, TOS_OFS_PERIOD, 32'(p));
      bus(1'b1, TOS_OFS_COMPARE, 32'(c));
      n0 = pulses;
      bus(1'b1, TOS_OFS_CTRL, ctrl_word(TOS_MODE_ONE_SHOT, 1'b1));
      ts = t_wr;
      wait_idle;
      repeat (8) @(posedge mclk_in);
      chk("os width", 32'(c + 1), 32'(width));
      chk("os pulses", 32'(n0) + 1, 32'(pulses));
      chk("os match time", 32'(ts + p + 2), 32'(t_match));
      chk("os drive off", 32'h0, 32'(pwm_drive_out));
      rd_chk(TOS_OFS_CTRL, ctrl_word(TOS_MODE_ONE_SHOT, 1'b0), "os run");
      rd_chk(TOS_OFS_COUNT, 32'h0, "os count");
    end
    // prescaled one-shot: a step every second cycle, the tick phase is free
    c = 4;
    bus(1'b1, TOS_OFS_PERIOD, 32'h10);
    bus(1'b1, TOS_OFS_COMPARE, 32'(c));
    bus(1'b1, TOS_OFS_CTRL, ctrl_word(TOS_MODE_ONE_SHOT, 1'b0) | (32'h1 << TOS_CTRL_PSC_LSB));
    bus(1'b1, TOS_OFS_CTRL, ctrl_word(TOS_MODE_ONE_SHOT, 1'b1) | (32'h1 << TOS_CTRL_PSC_LSB));
    wait_idle;
    repeat (8) @(posedge mclk_in);
    chk("psc width", 32'(c), 32'((width - 16'h0001) >> 1));
    bus(1'b1, TOS_OFS_CTRL, ctrl_word(TOS_MODE_ONE_SHOT, 1'b0));
    // one-shot with a pause in the drive and a pause after compare
    p = 60;
    c = 12;
    bus(1'b1, TOS_OFS_PERIOD, 32'(p));
    bus(1'b1, TOS_OFS_COMPARE, 32'(c));
    n0 = pulses;
    bus(1'b1, TOS_OFS_CTRL, ctrl_word(TOS_MODE_ONE_SHOT, 1'b1));
    ts = t_wr;
    bus(1'b1, TOS_OFS_CTRL, ctrl_word(TOS_MODE_ONE_SHOT, 1'b0));
    t1 = t_wr;
    rd_chk(TOS_OFS_COUNT, 32'(t1 - ts), "pause count");
    rd_chk(TOS_OFS_COUNT, 32'(t1 - ts), "paused count");
    rd_chk(TOS_OFS_STATUS, 32'h7, "paused status");
    bus(1'b1, TOS_OFS_CTRL, ctrl_word(TOS_MODE_ONE_SHOT, 1'b1));
    t2 = t_wr;
    while (pwm_drive_out === 1'b1 && cyc < 30000) @(posedge mclk_in);
    bus(1'b1, TOS_OFS_CTRL, ctrl_word(TOS_MODE_ONE_SHOT, 1'b0));
    t3 = t_wr;
    repeat (6) @(posedge mclk_in);
    bus(1'b1, TOS_OFS_CTRL, ctrl_word(TOS_MODE_ONE_SHOT, 1'b1));
    t4 = t_wr;
    wait_idle;
    chk("pause width", 32'(c + 1 + t2 - t1), 32'(width));
    chk("pause match", 32'(ts + p + 2 + t2 - t1 + t4 - t3), 32'(t_match));
    chk("pause pulses", 32'(n0) + 1, 32'(pulses));
    // monostable, each edge code against rising and falling trigger edges
    for (int k = 0; k < 3; k++) begin
      m = (k == 0) ? TOS_MODE_MONO_RISE : (k == 1) ? TOS_MODE_MONO_FALL : TOS_MODE_MONO_BOTH;
      p = 24 + ($unsigned($random(seed)) % 16);
      c = $unsigned($random(seed)) % p;
      bus(1'b1, TOS_OFS_PERIOD, 32'(p));
      bus(1'b1, TOS_OFS_COMPARE, 32'(c));
      bus(1'b1, TOS_OFS_CTRL, ctrl_word(m, 1'b1));
      for (int e = 0; e < 2; e++) begin
        n0 = pulses;
        tog;
        repeat (4) @(posedge mclk_in);
        bus(1'b0, TOS_OFS_STATUS, 32'h0);
        chk("mono start", 32'(exp_start(m, e == 0)), 32'(rd[TOS_STAT_ACTIVE]));
        if (exp_start(m, e == 0)) begin
          tog;
          tog;
          wait_idle;
          repeat (8) @(posedge mclk_in);
          chk("mono width", 32'(c + 1), 32'(width));
          chk("mono pulses", 32'(n0) + 1, 32'(pulses));
          rd_chk(TOS_OFS_COUNT, 32'(p), "mono hold");
        end else begin
          chk("mono idle", 32'(n0), 32'(pulses));
        end
      end
    end
    test_done;
  end
endmodule // tos_timer_top_tb
